//--- core/tcf_pkg.sv
package tcf_pkg;

    // ****************************************************************
    // Register map and field positions
    // ****************************************************************
    localparam logic [5:0]  FEATURE_ADDR     = 6'h20;
    localparam logic [5:0]  USER_OFFSET_ADDR = 6'h21;
    localparam logic [5:0]  USER_SCALE_ADDR  = 6'h22;
    localparam logic [15:0] FEATURE_RESET    = 16'h1006;
    localparam logic [15:0] USER_OFFSET_RST  = 16'h0000;
    localparam logic [15:0] USER_SCALE_RST   = 16'h0100;
    localparam logic [15:0] FEATURE_WMASK    = 16'hf51f;

    localparam int USER_SCALE_BIT   = 0;
    localparam int MFR_SCALE_BIT    = 1;
    localparam int WATCHDOG_BIT     = 2;
    localparam int SIGN_MAG_BIT     = 3;
    localparam int STATUS_LOW_BIT   = 4;
    localparam int CJC_OFF_BIT      = 8;
    localparam int NO_LOW_CHECK_BIT = 10;
    localparam int TYPE_LSB         = 12;

    // ****************************************************************
    // Control byte layout
    // ****************************************************************
    localparam int CTRL_REG_BIT = 7;
    localparam int CTRL_WR_BIT  = 6;

    // ****************************************************************
    // Scaling constants and status-field positions
    // ****************************************************************
    localparam int SCALE_FRAC_BITS = 8;
    localparam int STATUS_LSB      = 3;
    localparam int FLAG_RANGE_BIT  = 0;
    localparam int FLAG_ERROR_BIT  = 1;

    // ****************************************************************
    // Sensor type codes
    // ****************************************************************
    typedef enum logic [3:0] {
        TCF_TYPE_L  = 4'h0,
        TCF_TYPE_K  = 4'h1,
        TCF_TYPE_J  = 4'h2,
        TCF_TYPE_E  = 4'h3,
        TCF_TYPE_T  = 4'h4,
        TCF_TYPE_N  = 4'h5,
        TCF_TYPE_U  = 4'h6,
        TCF_TYPE_B  = 4'h7,
        TCF_TYPE_R  = 4'h8,
        TCF_TYPE_S  = 4'h9,
        TCF_TYPE_UV = 4'ha
    } tcf_sensor_t;

    // Decoded feature register contents.
    typedef struct packed {
        tcf_sensor_t sensorType;
        logic        noLowCheck;
        logic        cjcOff;
        logic        statusLow;
        logic        signMag;
        logic        watchdogOn;
        logic        mfrScaleOn;
        logic        userScaleOn;
    } tcf_mode_t;

    // One measured sample entering the formatter.
    typedef struct packed {
        logic [15:0] value;
        logic        outOfRange;
        logic        belowRange;
        logic        error;
    } tcf_sample_t;

endpackage

//--- core/tcf_feature_format.sv
`timescale 1ns/1ns
// Function
// - Feature bit 0 enables user linear scaling, cleared by default.
// - Manufacturer scaling enable bit, set by default.
// - Feature bit 2 enables the watchdog, set by default.
// - Bit 3 selects sign-magnitude output; minus one reads 0x8001.
// - Bit 4 selects status flags in the three low bits.
// - Bit 8 turns cold-junction compensation off; default on.
// - Bit 10 skips the lower range limit check.
// - Bits 15..12 select sensor type L,K,J,E,T,N,U,B for 0..7.
// - Manufacturer scaling only gives tenth degree or 6.4 uV counts.
// - No scaling gives sixteenth degree or 4 uV counts.
// - Status format puts the value in bits 15..3, sign in 15.
// - Status format: bit 0 out of range, bit 1 error, bit 2 zero.
// - A 16-bit signed user offset is added under user scaling.
// - User scale is 16-bit signed, weighted two to the minus eight.
// - Control bit 7 selects registers, bit 6 writes, 5..0 address.
module tcf_feature_format (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 cmdValid,
    input  wire logic [7:0]           ctrlByte,
    input  wire logic [15:0]          cmdData,
    output logic      [7:0]           statusByte,
    output logic      [15:0]          readData,
    input  wire logic                 sampleValid,
    input  wire tcf_pkg::tcf_sample_t sampleIn,
    output logic                      outValid,
    output logic      [15:0]          outWord,
    output tcf_pkg::tcf_mode_t        modeOut
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] featureReg;
    logic [15:0] userOffset;
    logic [15:0] userScale;
    logic [15:0] next_featureReg;
    logic [15:0] next_userOffset;
    logic [15:0] next_userScale;
    logic [7:0]  next_statusByte;
    logic [15:0] next_readData;
    logic [5:0]  regIndex;
    logic        regAccess;
    logic        regWrite;

    assign regIndex  = ctrlByte[5:0];
    assign regAccess = cmdValid && ctrlByte[tcf_pkg::CTRL_REG_BIT];
    assign regWrite  = regAccess && ctrlByte[tcf_pkg::CTRL_WR_BIT];

    // The handshake completes when the status byte mirrors the control
    // byte; a write acknowledges with the write bit cleared.
    always_comb begin
        next_featureReg = featureReg;
        next_userOffset = userOffset;
        next_userScale  = userScale;
        next_statusByte = statusByte;
        next_readData   = readData;
        if (regAccess) begin
            next_statusByte = {1'b1, 1'b0, regIndex};
            next_readData   = 16'h0000;
            if (regWrite) begin
                if (regIndex == tcf_pkg::FEATURE_ADDR) begin
                    next_featureReg = cmdData & tcf_pkg::FEATURE_WMASK;
                end else if (regIndex == tcf_pkg::USER_OFFSET_ADDR) begin
                    next_userOffset = cmdData;
                end else if (regIndex == tcf_pkg::USER_SCALE_ADDR) begin
                    next_userScale = cmdData;
                end
            end else begin
                if (regIndex == tcf_pkg::FEATURE_ADDR) begin
                    next_readData = featureReg;
                end else if (regIndex == tcf_pkg::USER_OFFSET_ADDR) begin
                    next_readData = userOffset;
                end else if (regIndex == tcf_pkg::USER_SCALE_ADDR) begin
                    next_readData = userScale;
                end
            end
        end else if (cmdValid) begin
            next_statusByte = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            featureReg <= tcf_pkg::FEATURE_RESET;
            userOffset <= tcf_pkg::USER_OFFSET_RST;
            userScale  <= tcf_pkg::USER_SCALE_RST;
            statusByte <= 8'h00;
            readData   <= 16'h0000;
        end else begin
            featureReg <= next_featureReg;
            userOffset <= next_userOffset;
            userScale  <= next_userScale;
            statusByte <= next_statusByte;
            readData   <= next_readData;
        end
    end

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    tcf_pkg::tcf_mode_t mode;

    always_comb begin
        mode.userScaleOn = featureReg[tcf_pkg::USER_SCALE_BIT];
        mode.mfrScaleOn  = featureReg[tcf_pkg::MFR_SCALE_BIT];
        mode.watchdogOn  = featureReg[tcf_pkg::WATCHDOG_BIT];
        mode.signMag     = featureReg[tcf_pkg::SIGN_MAG_BIT];
        mode.statusLow   = featureReg[tcf_pkg::STATUS_LOW_BIT];
        mode.cjcOff      = featureReg[tcf_pkg::CJC_OFF_BIT];
        mode.noLowCheck  = featureReg[tcf_pkg::NO_LOW_CHECK_BIT];
        mode.sensorType  = tcf_pkg::tcf_sensor_t'(
            featureReg[tcf_pkg::TYPE_LSB +: 4]);
    end

    assign modeOut = mode;

    // ****************************************************************
    // Output word formatter
    // ****************************************************************
    // The upstream converter delivers values already in the resolution
    // picked by the scaling bits (tenth or sixteenth degree); only the
    // user equation is applied here, so that path stays a single stage.
    function automatic logic [15:0] to_sign_mag(input logic [15:0] v);
        logic [15:0] mag;
        mag = v[15] ? 16'(-v) : v;
        return {v[15], mag[14:0]};
    endfunction

    logic [31:0] product;
    logic [15:0] scaled;
    logic [15:0] coded;
    logic        rangeFlag;
    logic [15:0] next_outWord;
    logic        next_outValid;

    always_comb begin
        product = 32'($signed(sampleIn.value) * $signed(userScale));
        if (mode.userScaleOn) begin
            scaled = 16'(product[tcf_pkg::SCALE_FRAC_BITS +: 16]
                          + userOffset);
        end else begin
            scaled = sampleIn.value;
        end
        rangeFlag = sampleIn.outOfRange
                    || (sampleIn.belowRange && !mode.noLowCheck);
        coded = mode.signMag ? to_sign_mag(scaled) : scaled;
        if (mode.statusLow) begin
            next_outWord = {coded[15], coded[14:0]};
            next_outWord[tcf_pkg::STATUS_LSB-1:0] = 3'h0;
            next_outWord[tcf_pkg::FLAG_RANGE_BIT] = rangeFlag;
            next_outWord[tcf_pkg::FLAG_ERROR_BIT] = sampleIn.error;
        end else begin
            next_outWord = coded;
        end
        next_outValid = sampleValid;
        if (!sampleValid) begin
            next_outWord = outWord;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            outWord  <= 16'h0000;
            outValid <= 1'b0;
        end else begin
            outWord  <= next_outWord;
            outValid <= next_outValid;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_featWrite;
        cmdValid && ctrlByte[7:6] == 2'b11
            && ctrlByte[5:0] == tcf_pkg::FEATURE_ADDR;
    endsequence

    chk_feature_reset: assert property (@(posedge core_clk)
        reset |=> featureReg == tcf_pkg::FEATURE_RESET)
        else $error("feature register reset value wrong");

    chk_feature_write: assert property (@(posedge core_clk)
        disable iff (reset) s_featWrite |=>
        featureReg == ($past(cmdData) & tcf_pkg::FEATURE_WMASK))
        else $error("feature write not stored");

    chk_write_ack: assert property (@(posedge core_clk)
        disable iff (reset) (cmdValid && ctrlByte[7]) |=>
        statusByte == {2'b10, $past(ctrlByte[5:0])})
        else $error("register acknowledge wrong");

    chk_sign_mag_out: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && mode.signMag && !mode.statusLow
        && !mode.userScaleOn && sampleIn.value == 16'hffff) |=>
        outWord == 16'h8001)
        else $error("sign magnitude minus one wrong");

    chk_status_range: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && mode.statusLow) |=>
        outWord[0] == $past(rangeFlag) && outWord[2] == 1'b0)
        else $error("status bits wrong");

    chk_status_error: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && mode.statusLow) |=>
        outWord[1] == $past(sampleIn.error))
        else $error("error flag wrong");

    chk_low_check: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && mode.statusLow
        && mode.noLowCheck && !sampleIn.outOfRange) |=>
        outWord[0] == 1'b0)
        else $error("low range check not skipped");

    chk_plain_pass: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && featureReg[4:0] == 5'h02) |=>
        outWord == $past(sampleIn.value))
        else $error("unscaled value altered");

    chk_user_offset: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && featureReg[4:0] == 5'h01
        && userScale == 16'h0100) |=>
        outWord == 16'($past(sampleIn.value) + userOffset))
        else $error("user offset not applied");

    chk_value_field: assert property (@(posedge core_clk)
        disable iff (reset) (sampleValid && mode.statusLow
        && !mode.signMag && !mode.userScaleOn) |=>
        outWord[15:3] == $past(sampleIn.value[15:3]))
        else $error("value field misplaced");

    chk_mode_bits: assert property (@(posedge core_clk)
        disable iff (reset) modeOut.watchdogOn == featureReg[2]
        && modeOut.cjcOff == featureReg[8]
        && modeOut.sensorType == featureReg[15:12])
        else $error("mode decode wrong");

endmodule

//--- tb/tcf_coupler_model.sv
`timescale 1ns/1ns
module tcf_coupler_model (
    input  wire logic        core_clk,
    output logic             cmdValid,
    output logic [7:0]       ctrlByte,
    output logic [15:0]      cmdData,
    input  wire logic [7:0]  statusByte,
    input  wire logic [15:0] readData
);
    initial begin
        cmdValid = 1'b0;
        ctrlByte = 8'h00;
        cmdData  = 16'h0000;
    end

    // ****************************************************************
    // Register access in control-byte register mode
    // ****************************************************************
    task automatic access(input logic wr, input logic [5:0] idx,
                          input logic [15:0] data, output logic [7:0] st,
                          output logic [15:0] rd);
        @(negedge core_clk);
        cmdValid = 1'b1;
        ctrlByte = {1'b1, wr, idx};
        cmdData  = data;
        @(negedge core_clk);
        st       = statusByte;
        rd       = readData;
        // Idle lines show the inverse so a stale word never looks valid.
        cmdValid = 1'b0;
        ctrlByte = ~ctrlByte;
        cmdData  = ~cmdData;
    endtask
endmodule

//--- tb/thermocouple_feature_output_format_test.sv
`timescale 1ns/1ns
module thermocouple_feature_output_format_test;
    logic                 core_clk;
    logic                 reset;
    logic                 cmdValid;
    logic [7:0]           ctrlByte;
    logic [15:0]          cmdData;
    logic [7:0]           statusByte;
    logic [15:0]          readData;
    logic                 sampleValid;
    tcf_pkg::tcf_sample_t sampleIn;
    logic                 outValid;
    logic [15:0]          outWord;
    tcf_pkg::tcf_mode_t   modeOut;
    logic [7:0]           st;
    logic [15:0]          rd;
    int                   err_count = 0;
    int                   n_tests = 0;
    logic [15:0] tFeat [11] = '{16'h1006, 16'h1004, 16'h100e, 16'h1016,
        16'h1016, 16'h1016, 16'h1016, 16'h1416, 16'h1007, 16'h1007, 16'h1006};
    logic [15:0] tVal [11] = '{16'hffff, 16'h0123, 16'hffff, 16'h000f,
        16'h0008, 16'h0008, 16'h0008, 16'h0008, 16'h0100, 16'hfff0, 16'h0100};
    logic [2:0] tFlg [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h1, 3'h2,
        3'h2, 3'h0, 3'h0, 3'h0};
    logic [15:0] tExp [11] = '{16'hffff, 16'h0123, 16'h8001, 16'h0008,
        16'h0009, 16'h000a, 16'h0009, 16'h0008, 16'h0210, 16'hfff0, 16'h0100};

    tcf_feature_format dut (
        .core_clk    (core_clk),
        .reset       (reset),
        .cmdValid    (cmdValid),
        .ctrlByte    (ctrlByte),
        .cmdData     (cmdData),
        .statusByte  (statusByte),
        .readData    (readData),
        .sampleValid (sampleValid),
        .sampleIn    (sampleIn),
        .outValid    (outValid),
        .outWord     (outWord),
        .modeOut     (modeOut)
    );

    tcf_coupler_model ctl (
        .core_clk   (core_clk),
        .cmdValid   (cmdValid),
        .ctrlByte   (ctrlByte),
        .cmdData    (cmdData),
        .statusByte (statusByte),
        .readData   (readData)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] mode_of(input logic [15:0] f);
        return {5'h00, f[15:12], f[10], f[8], f[4:0]};
    endfunction

    task automatic wr(input logic [5:0] idx, input logic [15:0] data);
        ctl.access(1'b1, idx, data, st, rd);
        check("write ack", {8'h00, st}, {8'h00, 2'b10, idx});
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp);
        ctl.access(1'b0, idx, 16'h5a5a, st, rd);
        check("read ack", {8'h00, st}, {8'h00, 2'b10, idx});
        check("read data", rd, exp);
    endtask

    task automatic feat(input logic [15:0] f);
        wr(tcf_pkg::FEATURE_ADDR, f);
        check("mode", {5'h00, modeOut}, mode_of(f));
    endtask

    task automatic sample(input logic [15:0] v, input logic [2:0] flg,
                          input logic [15:0] exp);
        @(negedge core_clk);
        sampleValid = 1'b1;
        sampleIn    = {v, flg};
        @(negedge core_clk);
        sampleValid = 1'b0;
        sampleIn    = ~sampleIn;
        check("out valid", {15'h0000, outValid}, 16'h0001);
        check("out word", outWord, exp);
        @(negedge core_clk);
        check("out valid pulse", {15'h0000, outValid}, 16'h0000);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        #200000;
        err_count++;
        $display("watchdog expired");
        results();
    end

    initial begin
        reset       = 1'b1;
        sampleValid = 1'b0;
        sampleIn    = '0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        check("reset word", outWord, 16'h0000);
        rdchk(tcf_pkg::FEATURE_ADDR, tcf_pkg::FEATURE_RESET);
        check("reset mode", {5'h00, modeOut}, mode_of(16'h1006));
        rdchk(tcf_pkg::USER_OFFSET_ADDR, 16'h0000);
        rdchk(tcf_pkg::USER_SCALE_ADDR, 16'h0100);
        rdchk(6'h05, 16'h0000);
        $display("test reset values done");
        feat(16'hffff);
        rdchk(tcf_pkg::FEATURE_ADDR, 16'hf51f);
        wr(6'h05, 16'h1234);
        rdchk(6'h05, 16'h0000);
        for (int i = 0; i <= 10; i++) begin
            feat({4'(i), 12'h006});
        end
        $display("test feature bits done");
        wr(tcf_pkg::USER_SCALE_ADDR, 16'h0200);
        wr(tcf_pkg::USER_OFFSET_ADDR, 16'h0010);
        rdchk(tcf_pkg::USER_SCALE_ADDR, 16'h0200);
        rdchk(tcf_pkg::USER_OFFSET_ADDR, 16'h0010);
        for (int i = 0; i < 11; i++) begin
            feat(tFeat[i]);
            sample(tVal[i], tFlg[i], tExp[i]);
        end
        // Unity user scale with manufacturer scaling off adds the offset.
        wr(tcf_pkg::USER_SCALE_ADDR, 16'h0100);
        feat(16'h1005);
        sample(16'h0040, 3'h0, 16'h0050);
        $display("test formatting done");
        // The controller sets its own scaling when using low-bit status.
        wr(tcf_pkg::USER_SCALE_ADDR, 16'h0800);
        wr(tcf_pkg::USER_OFFSET_ADDR, 16'h0000);
        feat(16'h1017);
        sample(16'h0002, 3'h0, 16'h0010);
        $display("test status scaling done");
        results();
    end
endmodule
